/* rtl/shsc_map.svh */
`ifndef SHSC_MAP_SVH
`define SHSC_MAP_SVH

// block and multiblock geometry
`define SHSC_BLK_W 64
`define SHSC_MB_BLKS 32
`define SHSC_MB_BITS 2048
`define SHSC_IDX_W 5
`define SHSC_LAST_BLK 5'h1F

// crc-12, 0x987 in implicit-one notation: taps below x^12 are 0x30F
`define SHSC_CRC_W 12
`define SHSC_CRC_TAPS 12'h30F

// fire code x^26 + x^21 + x^17 + x^9 + x^4 + 1, taps below x^26
`define SHSC_FEC_W 26
`define SHSC_FEC_TAPS 26'h0220211

// sync header mode selection codes
`define SHSC_MODE_W 2
`define SHSC_MODE_CRC 2'h0
`define SHSC_MODE_FEC 2'h2

// sync header stream layout
`define SHSC_SHS_W 32
`define SHSC_EOEMB_POS 22
`define SHSC_PILOT_LSB 27
`define SHSC_FEC_HI_CNT 22

// sync header encodings, first bit in [1]
`define SHSC_SH_ONE 2'h1
`define SHSC_SH_ZERO 2'h2
`define SHSC_SH_IDLE 2'h0

// serializer pre-emphasis setting width and reset value
`define SHSC_EMPH_W 4
`define SHSC_EMPH_RST 4'h0

`endif

/* rtl/shsc_pkg.sv */
`default_nettype none

package shsc_pkg;

   // position of a block in a multiblock or a multiblock in an ext mb
   typedef logic [4:0] shsc_idx_t;

   // sync header mode selection field
   typedef logic [1:0] shsc_mode_t;

   // link state, one-hot
   typedef enum logic [1:0] {
      SHSC_IDLE = 2'h1,
      SHSC_RUN = 2'h2
   } shsc_state_e;

endpackage
`default_nettype wire

/* rtl/shsc_crc12.sv */
`timescale 1ns/1ps
`default_nettype none
`include "shsc_map.svh"

module shsc_crc12 (
   input wire logic clk, // block clock
   input wire logic rst_n, // async reset, active low
   input wire logic clear, // realign: drop partial state
   input wire logic din_valid, // block present
   input wire logic din_last, // block 31 of the multiblock
   input wire logic [63:0] din, // scrambled block, bit 63 first
   output logic [11:0] parity, // crc of the last full multiblock
   output logic parity_valid // one-cycle pulse with new parity
);

   logic [11:0] state;
   wire [11:0] next_state;

   // sixty-four serial lfsr steps per block, msb of the block first
   function automatic logic [11:0] crc_step(input logic [11:0] s_in,
                                            input logic [63:0] d);
      logic [11:0] s;
      logic fb;
      s = s_in;
      fb = 1'b0;
      for (int i = 63; i >= 0; i--) begin
         fb = d[i] ^ s[11];
         s = {s[10:0], 1'b0} ^ ({12{fb}} & `SHSC_CRC_TAPS);
      end
      return s;
   endfunction

   assign next_state = crc_step(state, din);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= 12'h000;
         parity <= 12'h000;
         parity_valid <= 1'b0;
      end else begin
         parity_valid <= din_valid & din_last & ~clear;
         if (clear || (din_valid && din_last)) begin
            state <= 12'h000;
         end else if (din_valid) begin
            state <= next_state;
         end
         if (din_valid && din_last && !clear) begin
            parity <= next_state;
         end
      end
   end

endmodule
`default_nettype wire

/* rtl/shsc_fec26.sv */
`timescale 1ns/1ps
`default_nettype none
`include "shsc_map.svh"

module shsc_fec26 (
   input wire logic clk, // block clock
   input wire logic rst_n, // async reset, active low
   input wire logic clear, // realign: drop partial state
   input wire logic din_valid, // block present
   input wire logic din_last, // block 31 of the multiblock
   input wire logic [63:0] din, // scrambled block, bit 63 first
   output logic [25:0] parity, // fec parity of last multiblock
   output logic parity_valid // one-cycle pulse with new parity
);

   logic [25:0] state;
   wire [25:0] next_state;

   // systematic encoder: divide data by g(x), remainder is the parity
   function automatic logic [25:0] fec_step(input logic [25:0] s_in,
                                            input logic [63:0] d);
      logic [25:0] s;
      logic fb;
      s = s_in;
      fb = 1'b0;
      for (int i = 63; i >= 0; i--) begin
         fb = d[i] ^ s[25];
         s = {s[24:0], 1'b0} ^ ({26{fb}} & `SHSC_FEC_TAPS);
      end
      return s;
   endfunction

   assign next_state = fec_step(state, din);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= 26'h0000000;
         parity <= 26'h0000000;
         parity_valid <= 1'b0;
      end else begin
         parity_valid <= din_valid & din_last & ~clear;
         if (clear || (din_valid && din_last)) begin
            state <= 26'h0000000;
         end else if (din_valid) begin
            state <= next_state;
         end
         if (din_valid && din_last && !clear) begin
            parity <= next_state;
         end
      end
   end

endmodule
`default_nettype wire

/* rtl/shsc_top.sv */
// Overview of operation
// - crc mode: parity, zero commands, one filler and ext-mb flag placed
// - crc-12 runs over 32 scrambled blocks, sync headers excluded
// - crc-12 generator polynomial is 0x987
// - crc register cleared each multiblock, parity read after 2048 bits
// - mode field value 2 selects fec operation
// - fec parity of one multiblock sent in the next one
// - fec generator x^26+x^21+x^17+x^9+x^4+1, 9-bit burst correction
// - fec register zeroed each multiblock, parity read after 2048 bits
// - ext-mb flag is one only in the final multiblock
// - programmable pre-emphasis, larger value means stronger
// - every stream ends 00001, crc mode fills spare bits with ones
// - mode field value 0 selects crc-12 operation
// - sync header is 01 for a one, 10 for a zero
// - crc parity sent in the immediately following multiblock
`timescale 1ns/1ps
`default_nettype none
`include "shsc_map.svh"

module shsc_top (
   input wire logic clk, // block clock, 40 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic link_en, // level: run the lane
   input wire logic sysref_pulse, // pulse: reset lemc phase
   input wire shsc_pkg::shsc_mode_t sync_header_mode_sel, // 0 crc, 2 fec
   input wire shsc_pkg::shsc_idx_t emb_len_m1, // ext mb length minus 1
   input wire logic [`SHSC_EMPH_W-1:0] serializer_emphasis_level, // pe
   input wire logic blk_valid, // scrambled block present
   input wire logic [63:0] blk_data, // scrambled 64-bit block
   output logic [63:0] tx_data, // block to the serializer
   output logic [1:0] tx_sync_hdr, // header, first bit in [1]
   output logic tx_valid, // tx_data and tx_sync_hdr valid
   output logic tx_mb_last, // last block of a multiblock
   output logic tx_emb_last, // last block of an ext multiblock
   output logic lemc_pulse, // first block of an ext multiblock
   output logic tx_running, // lane is in the run state
   output logic [`SHSC_EMPH_W-1:0] ser_emph_drive // pe to driver
);

   import shsc_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // state

   shsc_state_e state;
   shsc_state_e next_state;
   shsc_idx_t blk_idx;
   shsc_idx_t mb_idx;
   shsc_idx_t emb_len;
   shsc_mode_t mode_cur;
   logic [`SHSC_CRC_W-1:0] crc_hold;
   logic [`SHSC_FEC_W-1:0] fec_hold;
   logic [`SHSC_EMPH_W-1:0] emph_cur;

   wire [`SHSC_CRC_W-1:0] crc_par;
   wire [`SHSC_FEC_W-1:0] fec_par;
   wire crc_par_valid;
   wire fec_par_valid;

   ////////////////////////////////////////////////////////////////////
   // stream layout

   // builds the 32-bit stream, index i is the bit of block i
   function automatic logic [31:0] build_stream(
      input shsc_mode_t mode,
      input logic [`SHSC_CRC_W-1:0] c,
      input logic [`SHSC_FEC_W-1:0] f,
      input logic eoemb);
      logic [31:0] s;
      s = 32'hFFFFFFFF;
      if (mode == `SHSC_MODE_FEC) begin
         for (int i = 0; i < `SHSC_FEC_HI_CNT; i++) begin
            s[i] = f[`SHSC_FEC_W-1-i];
         end
         for (int i = `SHSC_EOEMB_POS + 1; i < `SHSC_PILOT_LSB; i++) begin
            s[i] = f[`SHSC_FEC_W-i];
         end
      end else begin
         s[0] = c[11];
         s[1] = c[10];
         s[2] = c[9];
         s[4] = c[8];
         s[5] = c[7];
         s[6] = c[6];
         s[8] = c[5];
         s[9] = c[4];
         s[10] = c[3];
         s[12] = c[2];
         s[13] = c[1];
         s[14] = c[0];
         // command channel unused, always zero
         s[16] = 1'b0;
         s[17] = 1'b0;
         s[18] = 1'b0;
         s[20] = 1'b0;
         s[24] = 1'b0;
         s[25] = 1'b0;
         s[26] = 1'b0;
      end
      s[`SHSC_EOEMB_POS] = eoemb;
      // pilot 00001 closes every stream
      for (int i = `SHSC_PILOT_LSB; i < `SHSC_SHS_W - 1; i++) begin
         s[i] = 1'b0;
      end
      s[`SHSC_SHS_W-1] = 1'b1;
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // position decode

   wire running = (state == SHSC_RUN);
   wire take = running & blk_valid;
   wire blk_first = (blk_idx == 5'h00);
   wire blk_last = (blk_idx == `SHSC_LAST_BLK);
   wire mb_first = (mb_idx == 5'h00);
   wire emb_first = blk_first & mb_first;
   // leaving idle or taking sysref restarts the whole framing
   wire realign = sysref_pulse | ~running;

   // mode and ext-mb length are sampled at boundaries so a stream
   // never mixes two layouts; a mode change waits for the next multiblock, a length change for the next ext mb
   // fec select
   wire shsc_mode_t mode_eff = blk_first ? sync_header_mode_sel
                                         : mode_cur;
   wire shsc_idx_t emb_len_eff = emb_first ? emb_len_m1 : emb_len;
   wire mb_is_final = (mb_idx == emb_len_eff);

   wire eoemb = mb_is_final;

   // crc parity of previous
   // the coder pulse can share a cycle with block 0 of the next
   // multiblock, before the hold is loaded, so it is forwarded here
   wire [`SHSC_CRC_W-1:0] crc_use = crc_par_valid ? crc_par : crc_hold;
   wire [`SHSC_FEC_W-1:0] fec_use = fec_par_valid ? fec_par : fec_hold;
   wire [31:0] stream = build_stream(mode_eff, crc_use, fec_use, eoemb);

   wire shs_bit = stream[blk_idx];

   wire [1:0] sh_code = shs_bit ? `SHSC_SH_ONE : `SHSC_SH_ZERO;

   wire shsc_idx_t next_blk_idx = blk_last ? 5'h00 : blk_idx + 5'h01;
   wire shsc_idx_t next_mb_idx = (blk_last && mb_is_final) ? 5'h00
                                 : blk_last ? mb_idx + 5'h01 : mb_idx;

   ////////////////////////////////////////////////////////////////////
   // parity generators

   shsc_crc12 u_crc (
      .clk(clk),
      .rst_n(rst_n),
      .clear(realign),
      .din_valid(take),
      .din_last(blk_last),
      .din(blk_data),
      .parity(crc_par),
      .parity_valid(crc_par_valid)
   );

   // both coders run in every mode so a mode change finds fresh parity
   shsc_fec26 u_fec (
      .clk(clk),
      .rst_n(rst_n),
      .clear(realign),
      .din_valid(take),
      .din_last(blk_last),
      .din(blk_data),
      .parity(fec_par),
      .parity_valid(fec_par_valid)
   );

   ////////////////////////////////////////////////////////////////////
   // link state machine

   always_comb begin
      next_state = state;
      case (state)
         SHSC_IDLE: begin
            if (link_en) begin
               next_state = SHSC_RUN;
            end
         end
         SHSC_RUN: begin
            if (!link_en) begin
               next_state = SHSC_IDLE;
            end
         end
         default: begin
            next_state = SHSC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SHSC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // framing counters

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blk_idx <= 5'h00;
         mb_idx <= 5'h00;
      end else if (realign) begin
         blk_idx <= 5'h00;
         mb_idx <= 5'h00;
      end else if (take) begin
         blk_idx <= next_blk_idx;
         mb_idx <= next_mb_idx;
      end
   end

   // boundary samples of mode and ext-mb length
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_cur <= `SHSC_MODE_CRC;
         emb_len <= 5'h00;
      end else if (take) begin
         mode_cur <= mode_eff;
         emb_len <= emb_len_eff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // parity hold for the following multiblock

   // the hold is zero after a realign: the partial multiblock is lost
   // and the first stream after it carries no meaningful parity
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_hold <= 12'h000;
         fec_hold <= 26'h0000000;
      end else if (realign) begin
         crc_hold <= 12'h000;
         fec_hold <= 26'h0000000;
      end else begin
         if (crc_par_valid) begin
            crc_hold <= crc_par;
         end
         if (fec_par_valid) begin
            fec_hold <= fec_par;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pre-emphasis

   // stronger with larger value
   // taken only on a multiblock boundary or while idle, so the driver
   // never changes strength in the middle of a block stream
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         emph_cur <= `SHSC_EMPH_RST;
      end else if (!running || (take && blk_first)) begin
         emph_cur <= serializer_emphasis_level;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // transmit outputs, all registered

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_data <= 64'h0000000000000000;
         tx_sync_hdr <= `SHSC_SH_IDLE;
         tx_valid <= 1'b0;
         tx_mb_last <= 1'b0;
         tx_emb_last <= 1'b0;
      end else begin
         tx_valid <= take;
         tx_mb_last <= take & blk_last;
         tx_emb_last <= take & blk_last & mb_is_final;
         if (take) begin
            tx_data <= blk_data;
            tx_sync_hdr <= sh_code;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lemc_pulse <= 1'b0;
         tx_running <= 1'b0;
         ser_emph_drive <= `SHSC_EMPH_RST;
      end else begin
         lemc_pulse <= take & emb_first;
         tx_running <= running;
         ser_emph_drive <= emph_cur;
      end
   end

endmodule
`default_nettype wire

/* bench/shsc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "shsc_map.svh"

module shsc_checker (
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic link_en, // run
   input wire logic sysref_pulse, // realign
   input wire shsc_pkg::shsc_mode_t sync_header_mode_sel, // mode
   input wire shsc_pkg::shsc_idx_t emb_len_m1, // e-1
   input wire logic [`SHSC_EMPH_W-1:0] serializer_emphasis_level, // pe
   input wire logic blk_valid, // in valid
   input wire logic [63:0] blk_data, // in data
   input wire logic [63:0] tx_data, // out data
   input wire logic [1:0] tx_sync_hdr, // header
   input wire logic tx_valid, // out valid
   input wire logic tx_mb_last, // mb end
   input wire logic tx_emb_last, // emb end
   input wire logic lemc_pulse, // emb start
   input wire logic tx_running, // run state
   input wire logic [`SHSC_EMPH_W-1:0] ser_emph_drive // pe out
);
   import shsc_pkg::*;
   logic [4:0] nxt, mbi, e_q, emb_d;
   logic [1:0] mode_d, mode_mb;
   // block and multiblock position of the block now on the outputs
   wire [4:0] cur = lemc_pulse ? 5'h00 : nxt;
   wire [4:0] mbc = lemc_pulse ? 5'h00 : mbi;
   wire [4:0] ec = lemc_pulse ? emb_d : e_q;
   wire fec_cur = ((cur == 5'h00) ? mode_d : mode_mb) == `SHSC_MODE_FEC;

   // mode and e are taken with block 0, one cycle before it shows
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {nxt, mbi, e_q, emb_d, mode_d, mode_mb} <= '0;
      end else begin
         mode_d <= sync_header_mode_sel;
         emb_d <= emb_len_m1;
         if (tx_valid) begin
            nxt <= cur + 5'h01;
            mbi <= tx_mb_last ? mbc + 5'h01 : mbc;
            e_q <= ec;
            if (cur == 5'h00) begin
               mode_mb <= mode_d;
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // tx_running lags the lane state by one cycle, so it is read one
   // cycle after the edge that it describes
   hdr_code_a: assert property (tx_valid |-> tx_sync_hdr inside
      {`SHSC_SH_ONE, `SHSC_SH_ZERO}) else $error("illegal header");
   take_out_a: assert property (blk_valid ##1 tx_running |->
      tx_valid && tx_data == $past(blk_data)) else $error("block lost");
   idle_drop_a: assert property (!tx_running |-> !tx_valid)
      else $error("block sent while idle");
   mb_end_a: assert property (tx_valid |->
      tx_mb_last == (cur == 5'h1F)) else $error("multiblock end misplaced");
   pilot_a: assert property (tx_valid && cur > 5'h1A |->
      tx_sync_hdr == ((cur == 5'h1F) ? `SHSC_SH_ONE : `SHSC_SH_ZERO))
      else $error("end pattern wrong");
   crc_ones_a: assert property (tx_valid && !fec_cur &&
      cur inside {5'h03, 5'h07, 5'h0B, 5'h0F, 5'h13, 5'h15, 5'h17} |->
      tx_sync_hdr == `SHSC_SH_ONE) else $error("fixed one wrong");
   cmd_zero_a: assert property (tx_valid && !fec_cur &&
      cur inside {5'h10, 5'h11, 5'h12, 5'h14, 5'h18, 5'h19, 5'h1A} |->
      tx_sync_hdr == `SHSC_SH_ZERO) else $error("command bit not zero");
   eoemb_bit_a: assert property (tx_valid && cur == 5'h16 |->
      tx_sync_hdr == ((mbc == ec) ? `SHSC_SH_ONE : `SHSC_SH_ZERO))
      else $error("ext mb flag wrong");
   emb_last_a: assert property (tx_valid |->
      tx_emb_last == (tx_mb_last && mbc == ec)) else $error("emb end wrong");
   emph_pipe_a: assert property (!tx_running |=>
      ser_emph_drive == $past(serializer_emphasis_level, 2))
      else $error("emphasis not passed on");

   crc_mb_c: cover property (tx_valid && tx_mb_last && !fec_cur);
   fec_mb_c: cover property (tx_valid && tx_mb_last && fec_cur);
   emb_end_c: cover property (tx_valid && tx_emb_last);
   realign_c: cover property (tx_running && sysref_pulse);
endmodule

bind shsc_top shsc_checker u_shsc_checker (.clk(clk), .rst_n(rst_n),
   .link_en(link_en), .sysref_pulse(sysref_pulse),
   .sync_header_mode_sel(sync_header_mode_sel), .emb_len_m1(emb_len_m1),
   .serializer_emphasis_level(serializer_emphasis_level),
   .blk_valid(blk_valid), .blk_data(blk_data), .tx_data(tx_data),
   .tx_sync_hdr(tx_sync_hdr), .tx_valid(tx_valid), .tx_mb_last(tx_mb_last),
   .tx_emb_last(tx_emb_last), .lemc_pulse(lemc_pulse),
   .tx_running(tx_running), .ser_emph_drive(ser_emph_drive));
`default_nettype wire

/* bench/shsc_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "shsc_map.svh"

module shsc_rx_model (
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic sysref_pulse, // realign
   input wire shsc_pkg::shsc_mode_t sync_header_mode_sel, // mode
   input wire logic [63:0] tx_data, // block
   input wire logic [1:0] tx_sync_hdr, // header
   input wire logic tx_valid, // block present
   input wire logic tx_mb_last, // mb end
   input wire logic lemc_pulse, // emb start
   output logic mb_done, // pulse per mb
   output logic [25:0] syndrome, // own vs received parity
   output logic [7:0] pilot_run, // mbs in a row with end pattern
   output logic [7:0] hdr_bad // illegal headers
);
   import shsc_pkg::*;
   logic [11:0] crc, crc_prev;
   logic [25:0] fec, fec_prev;
   logic [31:0] shs;
   logic [4:0] idx;
   logic fec_mb;

   // both coders always run, so a mode switch between mbs is harmless
   always @(posedge clk or negedge rst_n) begin : rx_p
      logic [11:0] c, rc;
      logic [25:0] f, rf;
      logic [31:0] s;
      logic [4:0] k;
      logic m;
      if (!rst_n) begin
         {crc, crc_prev, fec, fec_prev, shs, idx, fec_mb} <= '0;
         {mb_done, syndrome, pilot_run, hdr_bad} <= '0;
      end else begin
         mb_done <= 1'b0;
         if (sysref_pulse) begin
            crc_prev <= 12'h000;
            fec_prev <= 26'h0000000;
         end
         if (tx_valid) begin
            k = lemc_pulse ? 5'h00 : idx;
            m = (sync_header_mode_sel == `SHSC_MODE_FEC);
            m = (k == 5'h00) ? m : fec_mb;
            c = (k == 5'h00) ? 12'h000 : crc;
            f = (k == 5'h00) ? 26'h0000000 : fec;
            s = shs;
            for (int i = 63; i >= 0; i--) begin
               c = {c[10:0], 1'b0}
                   ^ ((c[11] ^ tx_data[i]) ? 12'h30F : 12'h000);
               f = {f[24:0], 1'b0}
                   ^ ((f[25] ^ tx_data[i]) ? 26'h0220211 : 26'h0000000);
            end
            s[k] = (tx_sync_hdr == 2'h1);
            if (tx_sync_hdr[1] == tx_sync_hdr[0]) begin
               hdr_bad <= hdr_bad + 8'h01;
            end
            crc <= c;
            fec <= f;
            shs <= s;
            fec_mb <= m;
            idx <= k + 5'h01;
            if (tx_mb_last) begin
               for (int j = 0; j < 12; j++) rc[11 - j] = s[j + j / 3];
               for (int j = 0; j < 26; j++) rf[25 - j] = s[j < 22 ? j : j + 1];
               syndrome <= m ? (rf ^ fec_prev) : {14'h0000, rc ^ crc_prev};
               crc_prev <= c;
               fec_prev <= f;
               pilot_run <= (s[31:27] == 5'h10) ? pilot_run + 8'h01 : 8'h00;
               mb_done <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* bench/sync_header_stream_crc_fec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "shsc_map.svh"

module sync_header_stream_crc_fec_tb;
   import shsc_pkg::*;
   logic clk, rst_n, link_en, sysref_pulse, blk_valid, tx_valid, tx_mb_last;
   logic tx_emb_last, lemc_pulse, tx_running, mb_done;
   shsc_mode_t mode;
   shsc_idx_t emb_len_m1;
   logic [3:0] emph, ser_emph_drive;
   logic [63:0] blk_data, tx_data;
   logic [1:0] tx_sync_hdr;
   logic [25:0] syndrome;
   logic [7:0] pilot_run, hdr_bad;
   logic [31:0] seq;
   int mismatches, n_tests, cycles, n_done, n_emb;

   shsc_top u_shsc_top (.clk(clk), .rst_n(rst_n), .link_en(link_en),
      .sysref_pulse(sysref_pulse), .sync_header_mode_sel(mode),
      .emb_len_m1(emb_len_m1), .serializer_emphasis_level(emph),
      .blk_valid(blk_valid), .blk_data(blk_data), .tx_data(tx_data),
      .tx_sync_hdr(tx_sync_hdr), .tx_valid(tx_valid), .tx_mb_last(tx_mb_last),
      .tx_emb_last(tx_emb_last), .lemc_pulse(lemc_pulse),
      .tx_running(tx_running), .ser_emph_drive(ser_emph_drive));
   shsc_rx_model u_shsc_rx_model (.clk(clk), .rst_n(rst_n),
      .sysref_pulse(sysref_pulse), .sync_header_mode_sel(mode),
      .tx_data(tx_data), .tx_sync_hdr(tx_sync_hdr), .tx_valid(tx_valid),
      .tx_mb_last(tx_mb_last), .lemc_pulse(lemc_pulse), .mb_done(mb_done),
      .syndrome(syndrome), .pilot_run(pilot_run), .hdr_bad(hdr_bad));

   //////////////////////////////////////////////////////////////////////
   task check(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task test_done;
      if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // one block per call step, optionally with an idle cycle after each
   task send(input int n, input bit gap);
      repeat (n) begin
         @(posedge clk);
         blk_valid <= 1'b1;
         blk_data <= {seq, seq * 32'h9E3779B9};
         seq++;
         if (gap) begin
            @(posedge clk);
            blk_valid <= 1'b0;
         end
      end
      @(posedge clk);
      blk_valid <= 1'b0;
   endtask

   task t_idle(input logic [3:0] v);
      emph <= v;
      blk_valid <= 1'b1;
      repeat (3) @(posedge clk);
      blk_valid <= 1'b0;
      @(negedge clk);
      check("idle valid", {31'h0, tx_valid}, 32'h0);
      check("emphasis", {28'h0, ser_emph_drive}, {28'h0, v});
   endtask

   task t_start(input shsc_idx_t e);
      emb_len_m1 <= e;
      link_en <= 1'b1;
      @(posedge clk);
      sysref_pulse <= 1'b1;
      @(posedge clk);
      sysref_pulse <= 1'b0;
      send(1, 1'b0);
      @(negedge clk);
      check("lemc", {30'h0, tx_valid, lemc_pulse}, 32'h3);
   endtask

   task t_crc;
      int d, e;
      d = n_done;
      e = n_emb;
      @(posedge clk);
      mode <= `SHSC_MODE_CRC;
      t_start(5'h01);
      send(63, 1'b1);
      send(64, 1'b0);
      repeat (3) @(posedge clk);
      check("crc mbs", 32'(n_done - d), 32'h4);
      check("crc emb", 32'(n_emb - e), 32'h2);
   endtask

   // fec after fec, then codes 3, 1 and 0 as crc
   task automatic t_modes;
      shsc_mode_t tbl[5] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h0};
      int d;
      foreach (tbl[i]) begin
         mode <= tbl[i];
         d = n_done;
         send(32, 1'b0);
         repeat (3) @(posedge clk);
         check("mode mb", 32'(n_done - d), 32'h1);
      end
   endtask

   // sysref reissued mid-multiblock, one multiblock per ext mb
   task t_resync;
      int d, e;
      send(10, 1'b1);
      d = n_done;
      e = n_emb;
      t_start(5'h00);
      send(63, 1'b0);
      repeat (3) @(posedge clk);
      check("resync mbs", 32'(n_done - d), 32'h2);
      check("resync emb", 32'(n_emb - e), 32'h2);
   endtask

   task t_stop;
      send(5, 1'b0);
      link_en <= 1'b0;
      @(posedge clk);
      t_idle(4'h3);
      check("running", {31'h0, tx_running}, 32'h0);
   endtask

   //////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // parity is judged by the far-side model at every multiblock end
   always @(posedge clk) begin
      cycles++;
      if (mb_done === 1'b1) begin
         n_done++;
         check("syndrome", {6'h0, syndrome}, 32'h0);
      end
      if (tx_valid === 1'b1 && tx_emb_last === 1'b1) n_emb++;
      if (cycles == 4000) begin
         mismatches++;
         test_done;
      end
   end

   initial begin
      {rst_n, link_en, sysref_pulse, blk_valid, mode, emb_len_m1} = '0;
      emph = 4'h0;
      blk_data = 64'h0;
      seq = 32'h1;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check("reset header", {30'h0, tx_sync_hdr}, 32'h0);
      @(posedge clk);
      t_idle(4'hC);
      t_crc;
      t_modes;
      t_resync;
      t_stop;
      check("end pattern", {24'h0, pilot_run}, 32'(n_done));
      check("bad headers", {24'h0, hdr_bad}, 32'h0);
      test_done;
   end
endmodule
`default_nettype wire
